// file: tb/esc_enc_model.sv
// encoder model: zero pulses, oversampled streams, multi-turn position
`timescale 1ns/100ps
`default_nettype none

module esc_enc_model (
  // clock
  input  wire logic         clk,
  // encoder outputs
  output esc_pkg::esc_smp_t sc_smp,
  output logic              sc_stb,
  output esc_pkg::esc_smp_t res_smp,
  output logic              res_stb,
  output logic              zp1,
  output logic              zp3,
  output logic [31:0]       mt1,
  output logic [31:0]       mt3
);
  logic [1:0]  ph = 2'h0;
  logic [15:0] ramp = 16'h0000;

  initial begin
    {zp1, zp3, sc_stb, res_stb} = 4'h0;
    {sc_smp, res_smp, mt1, mt3} = '0;
  end

  // ==========================================================
  // strobes every fourth cycle; lines scrambled between strobes
  always @(posedge clk) begin
    ph      <= ph + 2'h1;
    ramp    <= ramp + 16'h0001;  // slow ramp, far under corner
    sc_stb  <= (ph == 2'h0);
    res_stb <= (ph == 2'h2);
    sc_smp  <= (ph == 2'h0) ? {ramp, ~ramp} : ~sc_smp;
    res_smp <= (ph == 2'h2) ? {~ramp, ramp} : ~res_smp;
  end

  // index pulse of w cycles, then low spacing
  task automatic pulse(input logic ch, input int w);
    @(posedge clk);
    if (ch) zp3 <= 1'b1;
    else zp1 <= 1'b1;
    repeat (w) @(posedge clk);
    zp1 <= 1'b0;
    zp3 <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic set_pos(input logic [31:0] p1, input logic [31:0] p3);
    mt1 <= p1;
    mt3 <= p3;
  endtask
endmodule
`default_nettype wire

// file: tb/esc_top_test.sv
// self-checking bench of the encoder conditioning block
`timescale 1ns/100ps
`default_nettype none

module esc_top_test;
  // 2048 turns of 2^20 increments
  localparam logic [31:0] SPAN = 32'h0000_0800 << 20;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, tick = 1'b0, mt_look = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, mt1, mt3, mo1, mo3;
  logic        pready, pslverr, pos_stb, hom1, hom3, zp1, zp3;
  logic        sc_stb, res_stb, ind1, ind3;
  esc_pkg::esc_enc_kind_t kind = esc_pkg::ESC_ENC_SINCOS;
  esc_pkg::esc_smp_t adc = '0, pos_smp, sc_smp, res_smp;
  logic [64:0] exp_rd[$];  // error, mask, value
  logic [33:0] exp_pos[$]; // differ, equal, value
  logic [63:0] exp_mt[$];
  logic [64:0] e;
  logic [33:0] p;
  int          mismatches = 0, n_compared = 0, nh1 = 0, nh3 = 0;
  int          seed = 35936;
  logic [15:0] hz[5] = '{16'h1a0a, 16'h0d05, 16'h0682, 16'h034c, 16'h01a0};

  always #12.5 clk = ~clk;

  esc_top i_esc_top (.CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CTRL_TICK(tick), .ENC_KIND(kind), .ADC_SMP(adc),
    .OVS_SINCOS_SMP(sc_smp), .OVS_SINCOS_STB(sc_stb),
    .OVS_RES_SMP(res_smp), .OVS_RES_STB(res_stb), .POS_SMP(pos_smp),
    .POS_STB(pos_stb), .CH1_MT_POS(mt1), .CH3_MT_POS(mt3),
    .CH1_MT_OUT(mo1), .CH3_MT_OUT(mo3), .ZP_CH1_IN(zp1),
    .ZP_CH3_IN(zp3), .ZERO_MARK_INDICATOR_CH1(ind1),
    .ZERO_MARK_INDICATOR_CH3(ind3), .HOMING_ZP_CH1(hom1),
    .HOMING_ZP_CH3(hom3));

  esc_enc_model u_enc (.clk(clk), .sc_smp(sc_smp), .sc_stb(sc_stb),
    .res_smp(res_smp), .res_stb(res_stb), .zp1(zp1), .zp3(zp3),
    .mt1(mt1), .mt3(mt3));

  // ==========================================================
  // shared checking and closing
  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // apb master: request held until pready seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk(1'b0, "bus hang");
      results();
    end
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] v, input logic err);
    exp_rd.push_back({err, m, v});
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] ctrl(input logic en, input logic src,
                                       input logic [3:0] c,
                                       input logic [6:0] pct);
    return {17'h0, pct, c, 2'h0, src, en};
  endfunction

  // tick with a fresh converter sample; md 1 equal, 2 differ, 0 skip
  task automatic tk(input int gap, input logic [1:0] md);
    logic [31:0] v;
    v = $random(seed);
    @(posedge clk);
    adc  <= esc_pkg::esc_smp_t'(v);
    tick <= 1'b1;
    exp_pos.push_back({md, v});
    @(posedge clk);
    tick <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask

  task automatic mt(input logic [31:0] p1, p3, e1, e3);
    @(posedge clk);
    u_enc.set_pos(p1, p3);
    exp_mt.push_back({e1, e3});
    @(posedge clk);
    mt_look <= 1'b1;
    @(posedge clk);
    mt_look <= 1'b0;
  endtask

  // ==========================================================
  // watcher: oldest note compared when a result shows
  always @(posedge clk) begin
    if (psel && pen && pready && !pwr) begin
      e = exp_rd.pop_front();
      chk((prdata & e[63:32]) === e[31:0] && pslverr === e[64], "read");
    end
    if (pos_stb === 1'b1) begin
      chk(exp_pos.size() > 0, "spare strobe");
      p = exp_pos.pop_front();
      chk(p[33:32] == 2'h0 || (pos_smp === p[31:0]) == p[32], "sample");
    end
    if (mt_look) chk({mo1, mo3} === exp_mt.pop_front(), "turns");
    if (hom1 === 1'b1) nh1++;
    if (hom3 === 1'b1) nh3++;
  end

  // hang guard, about 40k cycles
  initial begin
    #1000000;
    chk(1'b0, "run too long");
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] w1, w3;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(esc_pkg::OFS_OVS_CTRL, '1, 32'h0000_6440, 1'b0);
    rd(esc_pkg::OFS_ZP_CTRL, '1, 32'h0, 1'b0);
    rd(esc_pkg::OFS_STATUS, 32'h7, 32'h0, 1'b0);
    rd(12'h0f0, '1, 32'h0, 1'b1);
    for (int c = 3; c <= 9; c++) begin
      apb(1'b1, esc_pkg::OFS_OVS_CTRL, ctrl(1'b0, 1'b0, 4'(c), 7'h64));
      rd(esc_pkg::OFS_STATUS, 32'hffff_0000,
         {hz[c < 4 ? 0 : (c > 8 ? 4 : c - 4)], 16'h0}, 1'b0);
    end
    // source and encoder kind matrix: src is k[2], kind k[1:0]
    for (int k = 0; k < 8; k++) begin
      kind <= esc_pkg::esc_enc_kind_t'(k[1:0]);
      apb(1'b1, esc_pkg::OFS_OVS_CTRL, ctrl(1'b1, k[2], 4'h4, 7'h64));
      rd(esc_pkg::OFS_STATUS, 32'h4, {29'h0, k == 0 || k == 5, 2'h0}, 1'b0);
    end
    kind <= esc_pkg::ESC_ENC_OTHER;
    tk(2, 2'h1); // kind other keeps converter samples
    kind <= esc_pkg::ESC_ENC_SINCOS;
    apb(1'b1, esc_pkg::OFS_OVS_CTRL, ctrl(1'b0, 1'b0, 4'h4, 7'h00));
    tk(20, 2'h1);
    tk(20, 2'h1);
    rd(esc_pkg::OFS_STATUS, 32'h8, 32'h0, 1'b0);
    apb(1'b1, esc_pkg::OFS_OVS_CTRL, ctrl(1'b0, 1'b0, 4'h4, 7'h64));
    tk(20, 2'h1);
    tk(2, 2'h1);
    rd(esc_pkg::OFS_STATUS, 32'h8, 32'h8, 1'b0);
    apb(1'b1, esc_pkg::OFS_OVS_CTRL, ctrl(1'b1, 1'b0, 4'h4, 7'h64));
    tk(20, 2'h0);
    tk(20, 2'h2); // filtered, not converter
    w1 = $random(seed) | 32'h10;
    w3 = $random(seed) & 32'h7fff_ffff | 32'h10;
    apb(1'b1, esc_pkg::OFS_CH1_WRAP, w1);
    apb(1'b1, esc_pkg::OFS_CH3_WRAP, w3);
    rd(esc_pkg::OFS_CH3_WRAP, '1, w3, 1'b0);
    mt(w1 - 1, w3, w1 - 1 + SPAN, w3);
    mt(w1, w3 - 1, w1, w3 - 1 + SPAN);
    mt(32'h0, 32'hffff_ffff, SPAN, 32'hffff_ffff);
    apb(1'b1, esc_pkg::OFS_ZP_CTRL, 32'h3);
    u_enc.pulse(1'b0, 6);
    rd(esc_pkg::OFS_STATUS, 32'h3, 32'h1, 1'b0);
    u_enc.pulse(1'b0, 1);
    u_enc.pulse(1'b1, 4);
    rd(esc_pkg::OFS_STATUS, 32'h3, 32'h2, 1'b0);
    chk(nh1 == 0 && nh3 == 0, "homing in test");
    apb(1'b1, esc_pkg::OFS_ZP_CTRL, 32'h0);
    u_enc.pulse(1'b0, 2);
    u_enc.pulse(1'b1, 2);
    rd(esc_pkg::OFS_STATUS, 32'h3, 32'h0, 1'b0);
    chk(nh1 == 1 && nh3 == 1, "homing");
    rd(esc_pkg::OFS_CNT_CH1, '1, 32'h3, 1'b0);
    rd(esc_pkg::OFS_CNT_CH3, '1, 32'h2, 1'b0);
    @(posedge clk);
    chk(exp_pos.size() == 0 && exp_rd.size() == 0, "result missing");
    results();
  end
endmodule
`default_nettype wire

// file: verilog/esc_pkg.sv
// constants, types and register map of the encoder signal conditioning block
package esc_pkg;

  // ==========================================================================
  // data widths
  localparam int unsigned SMP_W     = 16;
  localparam int unsigned POS_W     = 32;
  localparam int unsigned CNT_W     = 32;
  localparam int unsigned FILT_FRAC = 8;
  localparam int unsigned ACC_W     = SMP_W + FILT_FRAC;

  // ==========================================================================
  // register byte offsets on the apb window
  localparam logic [11:0] OFS_OVS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CH1_WRAP = 12'h004;
  localparam logic [11:0] OFS_CH3_WRAP = 12'h008;
  localparam logic [11:0] OFS_ZP_CTRL  = 12'h00c;
  localparam logic [11:0] OFS_STATUS   = 12'h010;
  // counter bank: byte address is base plus four times the counter index
  localparam logic [11:0] OFS_CNT_BASE = 12'h100;
  localparam int unsigned CNT_IDX_CH1  = 31;
  localparam int unsigned CNT_IDX_CH3  = 32;
  localparam logic [11:0] OFS_CNT_CH1  = OFS_CNT_BASE + 12'(CNT_IDX_CH1 * 4);
  localparam logic [11:0] OFS_CNT_CH3  = OFS_CNT_BASE + 12'(CNT_IDX_CH3 * 4);

  // ==========================================================================
  // oversampling_control fields
  localparam int unsigned OVS_EN_BIT    = 0;
  localparam int unsigned OVS_SRC_BIT   = 1;
  localparam int unsigned OVS_SHIFT_LSB = 4;
  localparam int unsigned OVS_SHIFT_W   = 4;
  localparam int unsigned OVS_PMEAS_LSB = 8;
  localparam int unsigned OVS_PMEAS_W   = 7;
  // disabled, sin/cos source, corner code 4, window 100 percent
  localparam logic [31:0] OVS_CTRL_RST  = 32'h0000_6440;
  localparam logic [31:0] WRAP_RST      = 32'h0000_0000;
  localparam logic [6:0]  PCT_FULL      = 7'h64;
  localparam logic        SRC_SINCOS    = 1'b0;
  localparam logic        SRC_RESOLVER  = 1'b1;

  // zero-pulse test control and status bits
  localparam int unsigned ZP_CH1_BIT    = 0;
  localparam int unsigned ZP_CH3_BIT    = 1;
  localparam int unsigned ST_IND1_BIT   = 0;
  localparam int unsigned ST_IND3_BIT   = 1;
  localparam int unsigned ST_ACT_BIT    = 2;
  localparam int unsigned ST_WIN_BIT    = 3;
  localparam int unsigned ST_HZ_LSB     = 16;

  // ==========================================================================
  // filter corner codes
  localparam logic [3:0] FC_CODE_MIN = 4'h4;
  localparam logic [3:0] FC_CODE_MAX = 4'h8;

  // ==========================================================================
  // multi-turn travel: 2048 revolutions of 2^20 increments
  localparam int unsigned REV_BITS = 20;
  localparam int unsigned MT_REVS  = 2048;
  localparam logic [POS_W-1:0] MT_SPAN = POS_W'(MT_REVS) << REV_BITS;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ESC_ENC_SINCOS   = 2'b00,
    ESC_ENC_RESOLVER = 2'b01,
    ESC_ENC_OTHER    = 2'b10,
    ESC_ENC_NONE     = 2'b11
  } esc_enc_kind_t;

  typedef struct packed {
    logic signed [SMP_W-1:0] sin;
    logic signed [SMP_W-1:0] cos;
  } esc_smp_t;

  // corner frequency in hz for a clamped corner code
  function automatic logic [15:0] esc_fc_hz(input logic [3:0] code);
    logic [15:0] hz;
    hz = 16'h1a0a;                    // 6666 hz
    unique case (code)
      4'h5:    hz = 16'h0d05;         // 3333 hz
      4'h6:    hz = 16'h0682;         // 1666 hz
      4'h7:    hz = 16'h034c;         // 844 hz
      4'h8:    hz = 16'h01a0;         // 416 hz
      default: hz = 16'h1a0a;
    endcase
    return hz;
  endfunction

endpackage

// file: verilog/esc_top.sv
// encoder signal conditioning: oversampling, multi-turn shift, zero-pulse test
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - enabled oversampling replaces ordinary converter samples when source matches encoder kind
// - window is percentage of sampling period
// - corner codes 4..8 give 6666..416 hz
// - source 0 sin/cos, 1 resolver
// - positions below threshold move past 2048 turns
// - threshold in increments, 20-bit revolution
// - shift only on channels 1 and 3
// - test setting 1 enters zero-pulse test
// - indicator toggles on every zero pulse in test mode, held low otherwise
// - indicator widths show pulse spacing only
// - test mode hides pulses from homing
// - all pulses counted, indices 31 and 32
// - only resolver and sin/cos affected
module esc_top #(
  parameter int unsigned PER_W = 16
) (
  // clock and reset
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESETN,
  // apb slave
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [11:0]                 PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  // control sampling and encoder kind
  input  wire logic                        CTRL_TICK,
  input  wire esc_pkg::esc_enc_kind_t      ENC_KIND,
  // converter and oversampled sample streams
  input  wire esc_pkg::esc_smp_t           ADC_SMP,
  input  wire esc_pkg::esc_smp_t           OVS_SINCOS_SMP,
  input  wire logic                        OVS_SINCOS_STB,
  input  wire esc_pkg::esc_smp_t           OVS_RES_SMP,
  input  wire logic                        OVS_RES_STB,
  // samples to position evaluation
  output esc_pkg::esc_smp_t                POS_SMP,
  output logic                             POS_STB,
  // multi-turn positions
  input  wire logic [esc_pkg::POS_W-1:0]   CH1_MT_POS,
  input  wire logic [esc_pkg::POS_W-1:0]   CH3_MT_POS,
  output logic      [esc_pkg::POS_W-1:0]   CH1_MT_OUT,
  output logic      [esc_pkg::POS_W-1:0]   CH3_MT_OUT,
  // zero pulses
  input  wire logic                        ZP_CH1_IN,
  input  wire logic                        ZP_CH3_IN,
  output logic                             ZERO_MARK_INDICATOR_CH1,
  output logic                             ZERO_MARK_INDICATOR_CH3,
  output logic                             HOMING_ZP_CH1,
  output logic                             HOMING_ZP_CH3
);

  localparam int unsigned WIN_W = PER_W + esc_pkg::OVS_PMEAS_W;
  localparam int unsigned PW    = esc_pkg::POS_W;
  localparam int unsigned AW    = esc_pkg::ACC_W;

  // ==========================================================================
  // registers
  logic [31:0]                 ovs_ctrl_reg;
  logic [PW-1:0]               wrap_reg [2];
  logic [1:0]                  zp_ctrl_reg;
  logic [31:0]                 prdata_reg;
  logic [PER_W-1:0]            per_cnt_reg;
  logic [WIN_W-1:0]            win_lim_reg;
  logic signed [AW-1:0]        acc_sin_reg;
  logic signed [AW-1:0]        acc_cos_reg;
  esc_pkg::esc_smp_t           pos_reg;
  logic                        pos_stb_reg;
  logic [PW-1:0]               mt_out_reg [2];

  // ==========================================================================
  // apb decode
  wire setup_rd = PSEL & ~PENABLE & ~PWRITE;
  wire access   = PSEL & PENABLE;
  wire wr_en    = access & PWRITE;
  wire hit_ctrl = PADDR == esc_pkg::OFS_OVS_CTRL;
  wire hit_w1   = PADDR == esc_pkg::OFS_CH1_WRAP;
  wire hit_w3   = PADDR == esc_pkg::OFS_CH3_WRAP;
  wire hit_zp   = PADDR == esc_pkg::OFS_ZP_CTRL;
  wire hit_st   = PADDR == esc_pkg::OFS_STATUS;
  wire hit_c1   = PADDR == esc_pkg::OFS_CNT_CH1;
  wire hit_c3   = PADDR == esc_pkg::OFS_CNT_CH3;
  wire hit_any  = hit_ctrl | hit_w1 | hit_w3 | hit_zp | hit_st | hit_c1 | hit_c3;

  // zero-wait slave; unmapped addresses answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~hit_any;
  assign PRDATA  = prdata_reg;

  // ==========================================================================
  // oversampling settings
  wire                                  ovs_en = ovs_ctrl_reg[esc_pkg::OVS_EN_BIT];
  wire                                  ovs_src =
    ovs_ctrl_reg[esc_pkg::OVS_SRC_BIT];
  wire [esc_pkg::OVS_SHIFT_W-1:0]       sh_code =
    ovs_ctrl_reg[esc_pkg::OVS_SHIFT_LSB +: esc_pkg::OVS_SHIFT_W];
  wire [esc_pkg::OVS_PMEAS_W-1:0]       pmeas =
    ovs_ctrl_reg[esc_pkg::OVS_PMEAS_LSB +: esc_pkg::OVS_PMEAS_W];

  // codes outside 4..8 clamp to the nearest corner rather than run unfiltered
  wire [3:0] sh_eff =
    (sh_code < esc_pkg::FC_CODE_MIN) ? esc_pkg::FC_CODE_MIN :
    (sh_code > esc_pkg::FC_CODE_MAX) ? esc_pkg::FC_CODE_MAX : sh_code;
  wire [15:0] corner_hz = esc_pkg::esc_fc_hz(sh_eff);

  // source pick; the filter only runs for a matching encoder kind
  wire src_match =
    (ovs_src == esc_pkg::SRC_SINCOS   && ENC_KIND == esc_pkg::ESC_ENC_SINCOS) ||
    (ovs_src == esc_pkg::SRC_RESOLVER && ENC_KIND == esc_pkg::ESC_ENC_RESOLVER);
  wire ovs_active = ovs_en & src_match;
  wire esc_pkg::esc_smp_t ovs_smp =
    (ovs_src == esc_pkg::SRC_RESOLVER) ? OVS_RES_SMP : OVS_SINCOS_SMP;
  wire ovs_stb = (ovs_src == esc_pkg::SRC_RESOLVER) ? OVS_RES_STB
                                                    : OVS_SINCOS_STB;

  // ==========================================================================
  // measuring window: elapsed*100 stays below period*pmeas
  wire [WIN_W-1:0] per_len  = WIN_W'(per_cnt_reg) + WIN_W'(1);
  wire [WIN_W-1:0] elapsed  = WIN_W'(per_cnt_reg) * WIN_W'(esc_pkg::PCT_FULL);
  wire [WIN_W-1:0] lim_next = per_len * WIN_W'(pmeas);
  wire             win_open = elapsed < win_lim_reg;
  wire             per_full = &per_cnt_reg;

  // period counter restarts on each tick and saturates if ticks stop
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      per_cnt_reg <= '0;
      win_lim_reg <= '0;
    end else if (CTRL_TICK) begin
      per_cnt_reg <= '0;
      win_lim_reg <= lim_next;
    end else if (!per_full) begin
      per_cnt_reg <= per_cnt_reg + PER_W'(1);
    end
  end

  // ==========================================================================
  // first-order low-pass step: acc += (x - acc) >>> shift
  function automatic logic signed [AW-1:0] filt_step(
    input logic signed [AW-1:0]             acc,
    input logic signed [esc_pkg::SMP_W-1:0] x,
    input logic [3:0]                       sh
  );
    logic signed [AW:0] diff;
    logic signed [AW:0] step;
    diff = $signed({x[esc_pkg::SMP_W-1], x, {esc_pkg::FILT_FRAC{1'b0}}})
           - $signed({acc[AW-1], acc});
    step = diff >>> sh;
    return acc + $signed(step[AW-1:0]);
  endfunction

  wire filt_upd = ovs_active & ovs_stb & win_open;
  wire signed [AW-1:0] sin_next = filt_step(acc_sin_reg, ovs_smp.sin, sh_eff);
  wire signed [AW-1:0] cos_next = filt_step(acc_cos_reg, ovs_smp.cos, sh_eff);
  wire esc_pkg::esc_smp_t filt_smp = '{
    sin: acc_sin_reg[AW-1 -: esc_pkg::SMP_W],
    cos: acc_cos_reg[AW-1 -: esc_pkg::SMP_W]
  };

  // filter state; samples outside the window are dropped, not queued
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_sin_reg <= '0;
      acc_cos_reg <= '0;
    end else if (filt_upd) begin
      acc_sin_reg <= sin_next;
      acc_cos_reg <= cos_next;
    end
  end

  // ==========================================================================
  // sample handed to position evaluation once per control tick
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pos_reg     <= '0;
      pos_stb_reg <= 1'b0;
    end else begin
      pos_stb_reg <= CTRL_TICK;
      if (CTRL_TICK) begin
        pos_reg <= ovs_active ? filt_smp : ADC_SMP;
      end
    end
  end

  assign POS_SMP = pos_reg;
  assign POS_STB = pos_stb_reg;

  // ==========================================================================
  // multi-turn shift, channels 1 and 3 only; unsigned increments
  wire [PW-1:0] mt_in [2];
  assign mt_in[0] = CH1_MT_POS;
  assign mt_in[1] = CH3_MT_POS;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_mt
      wire below = mt_in[g] < wrap_reg[g];
      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          mt_out_reg[g] <= '0;
        end else begin
          mt_out_reg[g] <= below ? mt_in[g] + esc_pkg::MT_SPAN
                                 : mt_in[g];
        end
      end
    end
  endgenerate

  assign CH1_MT_OUT = mt_out_reg[0];
  assign CH3_MT_OUT = mt_out_reg[1];

  // ==========================================================================
  // zero-pulse channels
  logic [esc_pkg::CNT_W-1:0] cnt_ch1;
  logic [esc_pkg::CNT_W-1:0] cnt_ch3;

  esc_zp_chan u_zp1 (
    .clk       (CORE_CLK),
    .rst_n     (RESETN),
    .zp_in     (ZP_CH1_IN),
    .test_en   (zp_ctrl_reg[esc_pkg::ZP_CH1_BIT]),
    .indicator (ZERO_MARK_INDICATOR_CH1),
    .homing_zp (HOMING_ZP_CH1),
    .count     (cnt_ch1)
  );

  esc_zp_chan u_zp3 (
    .clk       (CORE_CLK),
    .rst_n     (RESETN),
    .zp_in     (ZP_CH3_IN),
    .test_en   (zp_ctrl_reg[esc_pkg::ZP_CH3_BIT]),
    .indicator (ZERO_MARK_INDICATOR_CH3),
    .homing_zp (HOMING_ZP_CH3),
    .count     (cnt_ch3)
  );

  // ==========================================================================
  // register writes and read data
  wire [31:0] status_word;
  assign status_word = {corner_hz, 12'h000, win_open, ovs_active,
                        ZERO_MARK_INDICATOR_CH3, ZERO_MARK_INDICATOR_CH1};

  wire [31:0] rd_mux =
    hit_ctrl ? ovs_ctrl_reg :
    hit_w1   ? wrap_reg[0]  :
    hit_w3   ? wrap_reg[1]  :
    hit_zp   ? {30'h0000_0000, zp_ctrl_reg} :
    hit_st   ? status_word  :
    hit_c1   ? cnt_ch1      :
    hit_c3   ? cnt_ch3      : 32'h0000_0000;

  // writes land at the access edge; read data captured in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ovs_ctrl_reg <= esc_pkg::OVS_CTRL_RST;
      wrap_reg[0]  <= esc_pkg::WRAP_RST;
      wrap_reg[1]  <= esc_pkg::WRAP_RST;
      zp_ctrl_reg  <= 2'b00;
      prdata_reg   <= 32'h0000_0000;
    end else begin
      if (wr_en && hit_ctrl) ovs_ctrl_reg <= PWDATA;
      if (wr_en && hit_w1) wrap_reg[0] <= PWDATA;
      if (wr_en && hit_w3) wrap_reg[1] <= PWDATA;
      if (wr_en && hit_zp) zp_ctrl_reg <= PWDATA[1:0];
      if (setup_rd) prdata_reg <= rd_mux;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_tick_conv;
    CTRL_TICK && !ovs_active;
  endsequence
  sequence s_tick_ovs;
    CTRL_TICK && ovs_active;
  endsequence

  a_pos_conv: assert property (s_tick_conv |=>
    POS_STB && POS_SMP == $past(ADC_SMP)) else $error("converter sample lost");
  a_pos_ovs: assert property (s_tick_ovs |=>
    POS_STB && POS_SMP == $past(filt_smp)) else $error("filtered sample lost");
  a_win_zero: assert property (CTRL_TICK && pmeas == '0 |=>
    !win_open [*2]) else $error("window open at zero percent");
  a_win_full: assert property (CTRL_TICK && pmeas == esc_pkg::PCT_FULL
    && per_cnt_reg > 0 |=> win_open) else $error("full window closed");
  a_corner_code: assert property (sh_code == 4'h4 |->
    corner_hz == 16'h1a0a) else $error("corner code 4 wrong");
  a_src_route: assert property (ovs_en && ovs_src == esc_pkg::SRC_RESOLVER
    && ENC_KIND == esc_pkg::ESC_ENC_RESOLVER |-> ovs_active)
    else $error("resolver route not active");
  a_other_kind: assert property (ENC_KIND == esc_pkg::ESC_ENC_OTHER |->
    !ovs_active) else $error("other encoder affected");
  a_filt_hold: assert property (!filt_upd |=>
    $stable(acc_sin_reg) && $stable(acc_cos_reg)) else $error("filter moved");
  a_mt_shift: assert property (CH1_MT_POS < wrap_reg[0] |=>
    CH1_MT_OUT == $past(CH1_MT_POS) + esc_pkg::MT_SPAN)
    else $error("multi-turn shift missing");
  a_mt_pass: assert property (CH3_MT_POS >= wrap_reg[1] |=>
    CH3_MT_OUT == $past(CH3_MT_POS)) else $error("multi-turn passthrough bad");
  a_rst_off: assert property ($rose(RESETN) |-> !ovs_en &&
    zp_ctrl_reg == 2'b00) else $error("reset state wrong");

  // routing, corner and per-channel checks; a stale window or a channel
  // mix-up would only show up as a slightly wrong position downstream
  a_corner_min: assert property (sh_code == 4'h8 |->
    corner_hz == 16'h01a0) else $error("corner code 8 wrong");
  a_corner_clamp: assert property (
    sh_code < esc_pkg::FC_CODE_MIN |-> sh_eff == esc_pkg::FC_CODE_MIN)
    else $error("low code not clamped");
  a_src_sincos: assert property (
    ovs_en && ovs_src == esc_pkg::SRC_SINCOS &&
    ENC_KIND == esc_pkg::ESC_ENC_SINCOS |-> ovs_active)
    else $error("sin/cos route not active");
  a_kind_none: assert property (
    ENC_KIND == esc_pkg::ESC_ENC_NONE |-> !ovs_active)
    else $error("absent encoder affected");
  a_tick_win: assert property (CTRL_TICK |=> per_cnt_reg == '0)
    else $error("period count not restarted");
  a_stb_pulse: assert property (!CTRL_TICK |=> !POS_STB)
    else $error("strobe without tick");
  a_pos_hold: assert property (!CTRL_TICK |=> $stable(POS_SMP))
    else $error("sample changed between ticks");
  a_mt_shift3: assert property (CH3_MT_POS < wrap_reg[1] |=>
    CH3_MT_OUT == $past(CH3_MT_POS) + esc_pkg::MT_SPAN)
    else $error("ch3 shift missing");
  a_mt_pass1: assert property (CH1_MT_POS >= wrap_reg[0] |=>
    CH1_MT_OUT == $past(CH1_MT_POS)) else $error("ch1 passthrough bad");

endmodule

`default_nettype wire

// file: verilog/esc_zp_chan.sv
// zero-pulse test, homing gate and event counter for one encoder channel
`timescale 1ns/100ps
`default_nettype none

module esc_zp_chan #(
  parameter int unsigned CNT_W = esc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // encoder side
  input  wire logic             zp_in,
  input  wire logic             test_en,
  // results
  output logic                  indicator,
  output logic                  homing_zp,
  output logic [CNT_W-1:0]      count
);

  logic             zp_prev_reg;
  logic             ind_reg;
  logic             ind_next;
  logic             hom_reg;
  logic [CNT_W-1:0] cnt_reg;
  wire              zp_rise = zp_in & ~zp_prev_reg;

  // indicator flips per pulse, so its widths show pulse spacing
  assign ind_next = !test_en ? 1'b0 : (zp_rise ? ~ind_reg : ind_reg);

  // edge detect, toggle, homing gate and counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zp_prev_reg <= 1'b0;
      ind_reg     <= 1'b0;
      hom_reg     <= 1'b0;
      cnt_reg     <= '0;
    end else begin
      zp_prev_reg <= zp_in;
      ind_reg     <= ind_next;
      hom_reg     <= zp_rise & ~test_en;
      cnt_reg     <= cnt_reg + CNT_W'(zp_rise);
    end
  end

  assign indicator = ind_reg;
  assign homing_zp = hom_reg;
  assign count     = cnt_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_zp_toggle: assert property (test_en && zp_rise ##1 test_en |->
    indicator != $past(indicator)) else $error("indicator did not toggle");
  a_ind_hold: assert property (!zp_rise && test_en ##1 test_en |->
    $stable(indicator)) else $error("indicator moved without a pulse");
  a_homing_gate: assert property ((zp_rise && test_en) |=>
    !homing_zp) else $error("homing pulse passed in test mode");
  a_zp_count: assert property (zp_rise |=>
    count == $past(count) + CNT_W'(1)) else $error("zero pulse not counted");

endmodule

`default_nettype wire
